// ### hdl/uprt_tx_status.sv
// Transmit command framer with completion flag and two-word status area.
`timescale 1ns/1ns
module uprt_tx_status
    import uprt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [uprt_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [uprt_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [uprt_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic trigger_condition_bit_i,
    input wire logic rx_frame_ok_i,
    input wire logic rx_first_byte_i,
    input wire logic [uprt_pkg::DATA_W-1:0] rx_err_i,
    input wire logic [uprt_pkg::DATA_W-1:0] rx_count_i,
    output logic [uprt_pkg::BYTE_W-1:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic completion_flag_o,
    output logic busy_o
);
    import uprt_pkg::*;

    uprt_state_type state_ff;
    uprt_state_type nxt_state;
    logic [DATA_W-1:0] err_ff;
    logic [DATA_W-1:0] nxt_err;
    logic [DATA_W-1:0] cnt_ff;
    logic [DATA_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] chk_start_ff;
    logic [DATA_W-1:0] chk_end_ff;
    logic [DATA_W-1:0] frame_len_ff;
    logic [DATA_W-1:0] index_ff;
    logic [DATA_W-1:0] const_cnt_ff;
    logic [DATA_W-1:0] ref_base_ff;
    logic [DATA_W-1:0] ref_ofs_ff;
    logic [DATA_W-1:0] ref_limit_ff;
    logic [DATA_W-1:0] var_len_ff;
    logic [DATA_W-1:0] var_size_ff;
    logic [DATA_W-1:0] scan_ff;
    logic [DATA_W-1:0] idx_ff;
    logic scan_vld_ff;
    logic trig_s1_ff;
    logic trig_s2_ff;
    logic trig_s3_ff;
    logic trig_evt;
    logic rx_mode;
    logic tx_accept;
    logic tx_abandon;
    logic status_clear;
    logic range_ok;
    logic lrc_odd;
    logic lrc_bad;
    logic [DATA_W-1:0] eval_err;
    logic send_done;
    logic rd_en;
    logic [FRAME_AW-1:0] rd_addr;
    logic [BYTE_W-1:0] rd_byte;
    logic [DATA_W:0] ref_sum;
    logic cmd_wr;

    // The trigger is a pin and passes two flip-flops before the edge detect.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_s3_ff <= 1'b0;
        end else begin
            trig_s1_ff <= trigger_condition_bit_i;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
        end
    end

    assign trig_evt = trig_s2_ff & ~trig_s3_ff;
    assign rx_mode = ctrl_ff[CTRL_RX_MODE];
    assign tx_accept = trig_evt && !rx_mode && (state_ff == ST_IDLE);
    assign tx_abandon = trig_evt && !rx_mode && (state_ff != ST_IDLE);
    assign cmd_wr = reg_wr_i && (reg_addr_i == REG_COMMAND);
    assign status_clear = tx_accept ||
        (trig_evt && rx_mode && !ctrl_ff[CTRL_ALWAYS]) ||
        (cmd_wr && reg_wdata_i[CMD_CLR_STATUS]);
    assign range_ok = (chk_start_ff <= chk_end_ff) &&
        (chk_end_ff < frame_len_ff);
    assign ref_sum = {1'b0, ref_base_ff} + {1'b0, ref_ofs_ff};

    always_comb begin
        eval_err = ZERO_WORD;
        if (ctrl_ff[CTRL_USE_BCC]) begin
            eval_err[ERR_BCC] = !range_ok;
            if (ctrl_ff[CTRL_LRC_SEL] && (lrc_odd || lrc_bad)) begin
                eval_err[ERR_BCC] = 1'b1;
            end
        end
        if (ctrl_ff[CTRL_USE_INDEX]) begin
            eval_err[ERR_INDEX] = index_ff >= const_cnt_ff;
        end
        if (ctrl_ff[CTRL_USE_REF]) begin
            eval_err[ERR_REF] = ref_sum > {1'b0, ref_limit_ff};
        end
        if (ctrl_ff[CTRL_USE_VAR]) begin
            eval_err[ERR_VAR] = var_len_ff[DATA_W-1] ||
                (var_len_ff > size_product(var_size_ff));
        end
    end

    assign send_done = ((state_ff == ST_SOUT) && tx_ready_i &&
        (idx_ff + ONE_WORD >= frame_len_ff)) ||
        ((state_ff == ST_EVAL) && (eval_err == ZERO_WORD) &&
        (frame_len_ff == ZERO_WORD));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (tx_accept) begin
                    if (ctrl_ff[CTRL_USE_BCC] && ctrl_ff[CTRL_LRC_SEL] &&
                        range_ok) begin
                        nxt_state = ST_SCAN;
                    end else begin
                        nxt_state = ST_EVAL;
                    end
                end
            end
            ST_SCAN: begin
                if (scan_ff == chk_end_ff) begin
                    nxt_state = ST_SCW1;
                end
            end
            ST_SCW1: nxt_state = ST_SCW2;
            ST_SCW2: nxt_state = ST_EVAL;
            ST_EVAL: begin
                if (eval_err != ZERO_WORD) begin
                    nxt_state = ST_IDLE;
                end else if (frame_len_ff == ZERO_WORD) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_state = ST_SRD;
                end
            end
            ST_SRD: nxt_state = ST_SWT;
            ST_SWT: nxt_state = ST_SOUT;
            ST_SOUT: begin
                if (tx_ready_i) begin
                    nxt_state = send_done ? ST_IDLE : ST_SRD;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scan_ff <= ZERO_WORD;
            scan_vld_ff <= 1'b0;
        end else begin
            scan_vld_ff <= (state_ff == ST_SCAN);
            if (tx_accept) begin
                scan_ff <= chk_start_ff;
            end else if (state_ff == ST_SCAN) begin
                scan_ff <= scan_ff + ONE_WORD;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idx_ff <= ZERO_WORD;
        end else if (state_ff == ST_EVAL) begin
            idx_ff <= ZERO_WORD;
        end else if ((state_ff == ST_SOUT) && tx_ready_i) begin
            idx_ff <= idx_ff + ONE_WORD;
        end
    end

    assign rd_en = (state_ff == ST_SCAN) || (state_ff == ST_SRD);
    assign rd_addr = (state_ff == ST_SCAN) ? scan_ff[FRAME_AW-1:0] :
        idx_ff[FRAME_AW-1:0];

    uprt_frame_mem #(
        .DW(BYTE_W),
        .AW(FRAME_AW)
    ) u_mem (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(reg_wr_i && (reg_addr_i == REG_FRAME_DATA)),
        .wr_addr_i(reg_wdata_i[BYTE_W+FRAME_AW-1:BYTE_W]),
        .wr_data_i(reg_wdata_i[BYTE_W-1:0]),
        .rd_en_i(rd_en),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_byte)
    );

    uprt_lrc_chk u_lrc (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clr_i(tx_accept),
        .byte_vld_i(scan_vld_ff),
        .byte_i(rd_byte),
        .odd_o(lrc_odd),
        .bad_o(lrc_bad)
    );

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
        end else if (state_ff == ST_SWT) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= rd_byte;
        end else if ((state_ff == ST_SOUT) && tx_ready_i) begin
            tx_valid_o <= 1'b0;
        end
    end

    // A new cause is ORed in after the clear, so a set in the clear cycle wins.
    always_comb begin
        nxt_err = status_clear ? ZERO_WORD : err_ff;
        if (state_ff == ST_EVAL) begin
            nxt_err = nxt_err | (eval_err & ~ERR_RSV_MASK);
        end
        if (tx_abandon) begin
            nxt_err[ERR_ABANDON] = 1'b1;
        end
        if (rx_mode) begin
            nxt_err = nxt_err | rx_err_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_ff <= ZERO_WORD;
        end else begin
            err_ff <= nxt_err;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= ZERO_WORD;
        end else if (send_done) begin
            cnt_ff <= frame_len_ff;
        end else if (rx_mode && rx_frame_ok_i) begin
            cnt_ff <= rx_count_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            completion_flag_o <= 1'b0;
        end else if (send_done || (rx_mode && rx_frame_ok_i)) begin
            completion_flag_o <= 1'b1;
        end else if (tx_accept || (trig_evt && rx_mode)) begin
            completion_flag_o <= 1'b0;
        end else if (cmd_wr && reg_wdata_i[CMD_CLR_DONE]) begin
            completion_flag_o <= 1'b0;
        end else if (rx_mode && rx_first_byte_i && !ctrl_ff[CTRL_RETAIN]) begin
            completion_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (nxt_state != ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff <= ZERO_WORD;
            chk_start_ff <= ZERO_WORD;
            chk_end_ff <= ZERO_WORD;
            frame_len_ff <= ZERO_WORD;
            index_ff <= ZERO_WORD;
            const_cnt_ff <= ZERO_WORD;
            ref_base_ff <= ZERO_WORD;
            ref_ofs_ff <= ZERO_WORD;
            ref_limit_ff <= ZERO_WORD;
            var_len_ff <= ZERO_WORD;
            var_size_ff <= ZERO_WORD;
        end else if (reg_wr_i) begin
            if (reg_addr_i == REG_CTRL) begin
                ctrl_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_CHK_START) begin
                chk_start_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_CHK_END) begin
                chk_end_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_FRAME_LEN) begin
                frame_len_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_INDEX) begin
                index_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_CONST_CNT) begin
                const_cnt_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_REF_BASE) begin
                ref_base_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_REF_OFS) begin
                ref_ofs_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_REF_LIMIT) begin
                ref_limit_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_VAR_LEN) begin
                var_len_ff <= reg_wdata_i;
            end else if (reg_addr_i == REG_VAR_SIZE) begin
                var_size_ff <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= ZERO_WORD;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= ZERO_WORD;
        end else if (reg_addr_i == REG_STATUS) begin
            reg_rdata_o <= err_ff;
        end else if (reg_addr_i == REG_COUNT) begin
            reg_rdata_o <= cnt_ff;
        end else if (reg_addr_i == REG_CTRL) begin
            reg_rdata_o <= ctrl_ff;
        end else if (reg_addr_i == REG_FRAME_LEN) begin
            reg_rdata_o <= frame_len_ff;
        end else if (reg_addr_i == REG_FLAGS) begin
            reg_rdata_o <= {14'h0000, busy_o, completion_flag_o};
        end else begin
            reg_rdata_o <= ZERO_WORD;
        end
    end

    abandon_flag_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (tx_abandon && (nxt_state != ST_IDLE)) |=>
        err_ff[ERR_ABANDON] && busy_o)
        else $error("busy trigger did not set the abandon bit");

    status_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (|($past(err_ff) & ~err_ff)) |-> $past(status_clear))
        else $error("status bit cleared without a trigger or clear");

    reserved_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL) |=>
        ((err_ff & ERR_RSV_MASK) == ($past(err_ff) & ERR_RSV_MASK)))
        else $error("transmit check touched a reserved bit");

    error_blocks_send_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL && eval_err != ZERO_WORD) |=>
        (state_ff == ST_IDLE) && !tx_valid_o && !completion_flag_o)
        else $error("frame sent or completed despite an error");

    done_count_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        send_done |=> completion_flag_o && (cnt_ff == $past(frame_len_ff)))
        else $error("completion without the frame byte count");

    send_order_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_SRD) |=> (state_ff == ST_SWT) ##1 tx_valid_o)
        else $error("frame byte not presented two cycles after read");

    range_err_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL && ctrl_ff[CTRL_USE_BCC] &&
        chk_start_ff > chk_end_ff) |=> err_ff[ERR_BCC])
        else $error("reversed check range did not set bit 0");

    index_err_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL && ctrl_ff[CTRL_USE_INDEX] &&
        index_ff >= const_cnt_ff) |=> err_ff[ERR_INDEX])
        else $error("unmatched index did not set bit 3");

    var_err_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL && ctrl_ff[CTRL_USE_VAR] &&
        var_len_ff[DATA_W-1]) |=> err_ff[ERR_VAR])
        else $error("negative length did not set bit 6");

    ref_err_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_ff == ST_EVAL && ctrl_ff[CTRL_USE_REF] &&
        ref_sum > {1'b0, ref_limit_ff}) |=> err_ff[ERR_REF])
        else $error("reference overrun did not set bit 5");

    retain_done_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_mode && ctrl_ff[CTRL_RETAIN] && completion_flag_o &&
        rx_first_byte_i && !trig_evt && !cmd_wr) |=> completion_flag_o)
        else $error("retained completion flag dropped");

    always_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_mode && ctrl_ff[CTRL_ALWAYS] && !cmd_wr &&
        rx_err_i == ZERO_WORD) |=> (err_ff == $past(err_ff)))
        else $error("always-enabled receive status changed");
endmodule

// ### hdl/uprt_pkg.sv
// Package with register map, field positions and states of the transmit status block.
package uprt_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int BYTE_W = 8;
    localparam int FRAME_AW = 6;

    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CHK_START = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CHK_END = 4'h4;
    localparam logic [ADDR_W-1:0] REG_FRAME_LEN = 4'h5;
    localparam logic [ADDR_W-1:0] REG_INDEX = 4'h6;
    localparam logic [ADDR_W-1:0] REG_CONST_CNT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_REF_BASE = 4'h8;
    localparam logic [ADDR_W-1:0] REG_REF_OFS = 4'h9;
    localparam logic [ADDR_W-1:0] REG_REF_LIMIT = 4'hA;
    localparam logic [ADDR_W-1:0] REG_VAR_LEN = 4'hB;
    localparam logic [ADDR_W-1:0] REG_VAR_SIZE = 4'hC;
    localparam logic [ADDR_W-1:0] REG_FRAME_DATA = 4'hD;
    localparam logic [ADDR_W-1:0] REG_COMMAND = 4'hE;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 4'hF;

    localparam int CTRL_RX_MODE = 0;
    localparam int CTRL_RETAIN = 1;
    localparam int CTRL_ALWAYS = 2;
    localparam int CTRL_USE_BCC = 3;
    localparam int CTRL_USE_REF = 4;
    localparam int CTRL_USE_VAR = 5;
    localparam int CTRL_USE_INDEX = 6;
    localparam int CTRL_LRC_SEL = 7;
    localparam int CMD_CLR_STATUS = 0;
    localparam int CMD_CLR_DONE = 1;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_BUSY = 1;

    localparam int ERR_BCC = 0;
    localparam int ERR_INDEX = 3;
    localparam int ERR_REF = 5;
    localparam int ERR_VAR = 6;
    localparam int ERR_ABANDON = 7;
    localparam logic [DATA_W-1:0] ERR_RSV_MASK = 16'hFF16;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [DATA_W-1:0] ONE_WORD = 16'h0001;

    localparam logic [BYTE_W-1:0] ASC_0 = 8'h30;
    localparam logic [BYTE_W-1:0] ASC_9 = 8'h39;
    localparam logic [BYTE_W-1:0] ASC_A = 8'h41;
    localparam logic [BYTE_W-1:0] ASC_F = 8'h46;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_SCAN = 8'h02,
        ST_SCW1 = 8'h04,
        ST_SCW2 = 8'h08,
        ST_EVAL = 8'h10,
        ST_SRD = 8'h20,
        ST_SWT = 8'h40,
        ST_SOUT = 8'h80
    } uprt_state_type;

    function automatic logic is_hex_ascii(input logic [BYTE_W-1:0] b);
        return ((b >= ASC_0) && (b <= ASC_9)) ||
               ((b >= ASC_A) && (b <= ASC_F));
    endfunction

    function automatic logic [DATA_W-1:0] size_product(
        input logic [DATA_W-1:0] packed_size);
        logic [DATA_W-1:0] bytes;
        logic [DATA_W-1:0] words;
        bytes = {8'h00, packed_size[7:0]};
        words = {8'h00, packed_size[15:8]};
        return DATA_W'(bytes * words);
    endfunction
endpackage

// ### hdl/uprt_frame_mem.sv
// Frame byte store with one write port and a registered read port.
`timescale 1ns/1ns
module uprt_frame_mem #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    input wire logic sys_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem_ff [0:(1<<AW)-1];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem_ff[rd_addr_i];
        end
    end
endmodule

// ### hdl/uprt_lrc_chk.sv
// Scanner that checks the check-code range for odd length and non-hex bytes.
`timescale 1ns/1ns
module uprt_lrc_chk
    import uprt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clr_i,
    input wire logic byte_vld_i,
    input wire logic [uprt_pkg::BYTE_W-1:0] byte_i,
    output logic odd_o,
    output logic bad_o
);
    import uprt_pkg::*;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            odd_o <= 1'b0;
        end else if (clr_i) begin
            odd_o <= 1'b0;
        end else if (byte_vld_i) begin
            odd_o <= ~odd_o;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bad_o <= 1'b0;
        end else if (clr_i) begin
            bad_o <= 1'b0;
        end else if (byte_vld_i && !is_hex_ascii(byte_i)) begin
            bad_o <= 1'b1;
        end
    end
endmodule

// ### dv/uprt_sink.sv
// Frame byte sink that takes bytes at once or once every eight cycles.
`timescale 1ns/1ns
module uprt_sink
    import uprt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic [uprt_pkg::BYTE_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output int nbytes_o,
    output logic [uprt_pkg::BYTE_W-1:0] last_o
);
    import uprt_pkg::*;

    logic [2:0] tick_ff;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_ff <= 3'h0;
            tx_ready_o <= 1'b0;
            nbytes_o <= 0;
            last_o <= 8'h00;
        end else begin
            tick_ff <= tick_ff + 3'h1;
            tx_ready_o <= !slow_i || (tick_ff == 3'h6);
            if (tx_valid_i && tx_ready_o) begin
                nbytes_o <= nbytes_o + 1;
                last_o <= tx_data_i;
            end
        end
    end
endmodule

// ### dv/tb.sv
// Self-checking bench for the transmit status block.
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    miscompares++; $display("unexpected %s %h %h", n, e, s); end end
module tb;
    import uprt_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic trig = 1'b0;
    logic rx_ok = 1'b0;
    logic rx_first = 1'b0;
    logic slow = 1'b0;
    logic [DATA_W-1:0] rx_err = 16'h0000;
    logic [DATA_W-1:0] rx_cnt = 16'h0000;
    logic [DATA_W-1:0] rdata;
    logic [BYTE_W-1:0] tx_data;
    logic [BYTE_W-1:0] last_byte;
    logic tx_valid, tx_ready, done, busy;
    int nbytes, base;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] cfg [10] = '{16'h0, 16'h3, 16'h4, 16'h0, 16'h1, 16'h0,
        16'h0, 16'hA, 16'h0, 16'h0101};
    logic [7:0] e_ctl [7] = '{8'h08, 8'h88, 8'h88, 8'h40, 8'h10, 8'h20,
        8'h20};
    logic [3:0] e_reg [7] = '{REG_CHK_END, REG_CHK_END, REG_FRAME_DATA,
        REG_INDEX, REG_REF_OFS, REG_VAR_LEN, REG_VAR_LEN};
    logic [15:0] e_bad [7] = '{16'h4, 16'h2, 16'h0147, 16'h1, 16'hB, 16'h2,
        16'h8000};
    logic [15:0] e_ok [7] = '{16'h3, 16'h3, 16'h0131, 16'h0, 16'h0, 16'h0,
        16'h0};
    int e_bit [7] = '{ERR_BCC, ERR_BCC, ERR_BCC, ERR_INDEX, ERR_REF, ERR_VAR,
        ERR_VAR};
    uprt_tx_status u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .trigger_condition_bit_i(trig),
        .rx_frame_ok_i(rx_ok), .rx_first_byte_i(rx_first),
        .rx_err_i(rx_err), .rx_count_i(rx_cnt), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .completion_flag_o(done), .busy_o(busy));
    uprt_sink u_sink (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .nbytes_o(nbytes), .last_o(last_byte));
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(string n, input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 `CHK(n, e, rdata)
    endtask
    // The pin is held long enough to pass the input synchroniser.
    task automatic fire();
        @(posedge sys_clk_i);
        trig <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        trig <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300 && busy !== 1'b0; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        #1 `CHK("busy", 1'b0, busy)
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd_chk("status", REG_STATUS, ZERO_WORD);
        rd_chk("count", REG_COUNT, ZERO_WORD);
        rd_chk("unmapped", REG_CHK_START, ZERO_WORD);
        for (int i = 0; i < 4; i++) wr_reg(REG_FRAME_DATA, 16'(257 * i + 48));
        for (int i = 0; i < 10; i++) wr_reg(4'(i + 3), cfg[i]);
        base = nbytes;
        fire();
        wait_idle();
        `CHK("done", 1'b1, done)
        `CHK("sent", 4, nbytes - base)
        `CHK("last", 8'h33, last_byte)
        rd_chk("count", REG_COUNT, 16'h0004);
        rd_chk("flags", REG_FLAGS, ONE_WORD);
        for (int i = 0; i < 7; i++) begin
            wr_reg(REG_CTRL, {8'h00, e_ctl[i]});
            wr_reg(e_reg[i], e_bad[i]);
            base = nbytes;
            fire();
            wait_idle();
            rd_chk("err", REG_STATUS, ONE_WORD << e_bit[i]);
            `CHK("done", 1'b0, done)
            `CHK("sent", 0, nbytes - base)
            wr_reg(e_reg[i], e_ok[i]);
        end
        wr_reg(REG_CTRL, ZERO_WORD);
        slow <= 1'b1;
        fire();
        fire();
        wait_idle();
        slow <= 1'b0;
        rd_chk("abandon", REG_STATUS, 16'h0080);
        `CHK("done", 1'b1, done)
        wr_reg(REG_COMMAND, 16'h0003);
        #1 `CHK("done", 1'b0, done)
        wr_reg(REG_CTRL, 16'h0003);
        rx_cnt <= 16'h0005;
        rx_ok <= 1'b1;
        @(posedge sys_clk_i);
        rx_ok <= 1'b0;
        rx_first <= 1'b1;
        @(posedge sys_clk_i);
        rx_first <= 1'b0;
        @(posedge sys_clk_i);
        #1 `CHK("retain", 1'b1, done)
        rd_chk("rxcount", REG_COUNT, 16'h0005);
        wr_reg(REG_CTRL, 16'h0005);
        rx_err <= 16'h0004;
        @(posedge sys_clk_i);
        rx_err <= 16'h0000;
        fire();
        rd_chk("always", REG_STATUS, 16'h0004);
        wr_reg(REG_COMMAND, ONE_WORD);
        rd_chk("cleared", REG_STATUS, ZERO_WORD);
        tally_and_finish();
    end
endmodule
